// File: logic/dvi_pixel_params.svh
// Purpose: offsets, field positions, reset values of the pixel input port
// Assumes: included by bare name
// Notes:   apb byte offsets, one 32-bit word per register
`ifndef DVI_PIXEL_PARAMS_SVH
`define DVI_PIXEL_PARAMS_SVH

`define OFS_CTRL        12'h000
`define OFS_STATUS      12'h004
`define OFS_CFG         12'h008

`define CTRL_BUS24      0
`define CTRL_EDGE_RISE  1
`define CTRL_DIFF       2
`define CTRL_DESKEW     3
`define CTRL_SENSE      4
`define CTRL_TRIM_LO    5
`define CTRL_TRIM_HI    7
`define CTRL_RESET      8'h13

`define ST_RX           0
`define ST_MODE24       1
`define ST_DIFF         2
`define ST_SERIAL       3
`define ST_HOTPLUG      4
`define ST_HALF         5
`define ST_ROLE_LO      6
`define ST_ROLE_HI      7

`define DESKEW_DEFAULT  3'h0
`define TRIM_TAPS       8
`define SENSE_LEVEL     1'b0
`define MODE24_RESET    1'b1
`define EDGE_RESET      1'b1

`endif

// File: logic/dvi_pixel_pkg.sv
// Purpose: types shared by the pixel input port
// Assumes: nothing
// Notes:   constants live in dvi_pixel_params.svh
package dvi_pixel_pkg;
  typedef logic [31:0] apb_word_t;
  typedef logic [11:0] apb_addr_t;
  typedef enum logic [1:0] {
    ROLE_CTRL = 2'b00,
    ROLE_TRIM = 2'b01,
    ROLE_ADDR = 2'b10
  } pin_role_t;
  typedef enum logic {
    CAP_FIRST  = 1'b0,
    CAP_SECOND = 1'b1
  } cap_state_t;
endpackage

// File: logic/sync2.sv
// Purpose: two-flop synchroniser for a bundle of level inputs
// Assumes: each bit is a slow level relative to clock
// Notes:   stage one is read only by stage two
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

// File: logic/dvi_pixel_port.sv
// Purpose: pixel input port of a dvi transmitter, apb configured
// Assumes: pixel clock far slower than clock, every pin synchronised
// Notes:   edges of the pixel clock are found by oversampling
// What this block does
// [RQ1] 24-bit mode: lower twelve pixel pins form the pixel's bottom half.
// [RQ2] 12-bit mode: a 12-bit half is captured on every latch edge.
// [RQ3] single-ended clocking: controller drives positive input, negative grounded.
// [RQ4] differential mode: positive-over-negative crossing is the capture reference.
// [RQ5] differential clocking only allowed in low-swing mode.
// [RQ6] data enable high: the 24-bit pixel word is encoded.
// [RQ7] blanking: syncs and three control inputs are encoded instead.
// [RQ8] multifunction pins read zero when left unconnected.
// [RQ9] pin mode, no de-skew: multifunction pins are link control inputs.
// [RQ10] pin mode, de-skew on: multifunction pins give the trim code.
// [RQ11] serial mode: multifunction pins are low slave address bits.
// [RQ12] pin mode: sense output pulled low while a receiver is present.
// [RQ13] serial mode: sense output level is set by software.
// [RQ14] 12-bit mode: upper eight pixel pins sampled into a status byte.
// [RQ15] pin mode: bus-width strap high is 24-bit, low 12-bit.
// [RQ16] pin mode: edge strap high latches on rising, low on falling.
// [RQ17] dual-edge: two halves join into one pixel before encoding.
//
// Decided for this implementation: the address map and register access over APB.
`include "dvi_pixel_params.svh"
module dvi_pixel_port #(
  parameter int TAPS = `TRIM_TAPS
) (
  input  wire logic                    clock,
  input  wire logic                    sys_rst,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire dvi_pixel_pkg::apb_addr_t paddr,
  input  wire dvi_pixel_pkg::apb_word_t pwdata,
  output dvi_pixel_pkg::apb_word_t      prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic                    pix_clk_pos,
  input  wire logic                    pix_clk_neg,
  input  wire logic [23:0]             pix_data,
  input  wire logic                    data_enable,
  input  wire logic                    hsync,
  input  wire logic                    vsync,
  input  wire logic [2:0]              multi_pin,
  input  wire logic [2:0]              multi_pin_open,
  input  wire logic                    serial_if_select,
  input  wire logic                    deskew_enable,
  input  wire logic                    bus_width_strap,
  input  wire logic                    clock_type_strap,
  input  wire logic                    edge_select_strap,
  input  wire logic                    low_swing_mode,
  input  wire logic                    hot_plug_in,
  input  wire logic                    receiver_detect,
  output logic                         enc_valid,
  output logic                         enc_de,
  output logic [23:0]                  enc_pixel,
  output logic                         enc_hsync,
  output logic                         enc_vsync,
  output logic [2:0]                   link_ctrl_in,
  output logic [2:0]                   deskew_trim,
  output logic [2:0]                   slave_addr_low,
  output logic                         monitor_sense,
  output logic                         monitor_sense_oe_n
);
  import dvi_pixel_pkg::*;

  localparam int SW = 43;
  localparam int HD = TAPS + 1;

  logic [SW-1:0] raw;
  logic [SW-1:0] syn;
  logic [23:0]   data_s;
  logic          de_s;
  logic          hs_s;
  logic          vs_s;
  logic          pos_s;
  logic          neg_s;
  logic [2:0]    pins_s;
  logic [2:0]    open_s;
  logic          ser_s;
  logic          dsk_s;
  logic          width_s;
  logic          ctype_s;
  logic          edge_s;
  logic          lsw_s;
  logic          hpd_s;
  logic          rx_s;
  logic [2:0]    pins_eff;
  logic [7:0]    ctrl;
  logic [7:0]    cfg_byte;
  logic          mode24;
  logic          edge_rise;
  logic          diff_active;
  pin_role_t     pin_role;
  logic          ref_s;
  logic          ref_d;
  logic          rise;
  logic          fall;
  logic          prim;
  logic          sec;
  logic [26:0]   hist [HD];
  logic [3:0]    tap_idx;
  logic [26:0]   tap;
  logic [23:0]   tap_pix;
  cap_state_t    cap_state;
  logic [11:0]   first_half;
  logic [2:0]    first_ctl;
  logic          emit;
  logic [23:0]   pix_w;
  logic          de_w;
  logic          hs_w;
  logic          vs_w;
  logic          acc;
  logic          hit;
  apb_word_t     read_val;

  function automatic pin_role_t role_of(input logic ser, input logic dsk);
    pin_role_t r;
    r = ROLE_CTRL;
    if (ser) begin
      r = ROLE_ADDR;
    end else if (dsk) begin
      r = ROLE_TRIM;
    end
    return r;
  endfunction

  assign raw = {pix_data, data_enable, hsync, vsync, pix_clk_pos,
                pix_clk_neg, multi_pin, multi_pin_open, serial_if_select,
                deskew_enable, bus_width_strap, clock_type_strap,
                edge_select_strap, low_swing_mode, hot_plug_in,
                receiver_detect};

  sync2 #(.W(SW)) u_sync (
    .clock   (clock),
    .sys_rst (sys_rst),
    .d       (raw),
    .q       (syn)
  );

  assign {data_s, de_s, hs_s, vs_s, pos_s, neg_s, pins_s, open_s, ser_s,
          dsk_s, width_s, ctype_s, edge_s, lsw_s, hpd_s, rx_s} = syn;

  // open pins are held down by the pad pulldown
  assign pins_eff = pins_s & ~open_s; // [RQ8]

  // mode selection: straps in pin mode, ctrl register in serial mode
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      mode24      <= `MODE24_RESET;
      edge_rise   <= `EDGE_RESET;
      diff_active <= 1'b0;
      pin_role    <= ROLE_CTRL;
    end else begin
      pin_role <= role_of(ser_s, dsk_s); // [RQ9] [RQ10] [RQ11]
      if (ser_s) begin
        mode24      <= ctrl[`CTRL_BUS24];
        edge_rise   <= ctrl[`CTRL_EDGE_RISE];
        diff_active <= ctrl[`CTRL_DIFF] & lsw_s; // [RQ5]
      end else begin
        mode24      <= width_s; // [RQ15]
        edge_rise   <= edge_s; // [RQ16]
        diff_active <= ctype_s & lsw_s; // [RQ5]
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      deskew_trim <= `DESKEW_DEFAULT;
    end else if (!ser_s && dsk_s) begin
      deskew_trim <= pins_eff; // [RQ10]
    end else if (ser_s && ctrl[`CTRL_DESKEW]) begin
      deskew_trim <= ctrl[`CTRL_TRIM_HI:`CTRL_TRIM_LO];
    end else begin
      deskew_trim <= `DESKEW_DEFAULT;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      slave_addr_low <= 3'h0;
    end else if (ser_s) begin
      slave_addr_low <= pins_eff; // [RQ11]
    end
  end

  // negative input is ignored single-ended, so a grounded one is harmless
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ref_s <= 1'b0;
      ref_d <= 1'b0;
    end else begin
      ref_s <= diff_active ? (pos_s & ~neg_s) : pos_s; // [RQ4] [RQ3]
      ref_d <= ref_s;
    end
  end

  assign rise = ref_s & ~ref_d;
  assign fall = ~ref_s & ref_d;
  assign prim = edge_rise ? rise : fall; // [RQ16]
  assign sec  = edge_rise ? fall : rise;

  // history of samples; tap 1 lines up with the sample before the edge
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      hist[0] <= '0;
    end else begin
      hist[0] <= {data_s, de_s, hs_s, vs_s};
    end
  end

  for (genvar i = 1; i < HD; i++) begin : g_hist
    always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
        hist[i] <= '0;
      end else begin
        hist[i] <= hist[i-1];
      end
    end
  end

  // larger trim takes an older sample, i.e. captures earlier
  assign tap_idx = {1'b0, deskew_trim} + 4'h1; // [RQ10]
  assign tap     = hist[tap_idx];
  assign tap_pix = tap[26:3];

  always_comb begin
    emit  = 1'b0;
    pix_w = tap_pix; // [RQ1]
    de_w  = tap[2];
    hs_w  = tap[1];
    vs_w  = tap[0];
    if (mode24) begin
      emit = prim;
    end else if (cap_state == CAP_SECOND) begin
      emit  = sec;
      pix_w = {tap_pix[11:0], first_half}; // [RQ17]
      de_w  = first_ctl[2];
      hs_w  = first_ctl[1];
      vs_w  = first_ctl[0];
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cap_state  <= CAP_FIRST;
      first_half <= 12'h000;
      first_ctl  <= 3'h0;
    end else if (mode24) begin
      cap_state <= CAP_FIRST;
    end else begin
      case (cap_state)
        CAP_FIRST: begin
          if (prim) begin
            first_half <= tap_pix[11:0]; // [RQ2]
            first_ctl  <= tap[2:0];
            cap_state  <= CAP_SECOND;
          end
        end
        CAP_SECOND: begin
          if (sec) begin
            cap_state <= CAP_FIRST; // [RQ2]
          end
        end
        default: begin
          cap_state <= CAP_FIRST;
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      enc_valid    <= 1'b0;
      enc_de       <= 1'b0;
      enc_pixel    <= 24'h000000;
      enc_hsync    <= 1'b0;
      enc_vsync    <= 1'b0;
      link_ctrl_in <= 3'h0;
    end else begin
      enc_valid <= emit;
      if (emit) begin
        enc_de       <= de_w;
        enc_pixel    <= de_w ? pix_w : 24'h000000; // [RQ6]
        enc_hsync    <= hs_w; // [RQ7]
        enc_vsync    <= vs_w;
        link_ctrl_in <= (!de_w && pin_role == ROLE_CTRL) ? pins_eff
                                                          : 3'h0; // [RQ9]
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_byte <= 8'h00;
    end else if (!mode24 && prim) begin
      cfg_byte <= tap_pix[23:16]; // [RQ14]
    end
  end

  // open drain: enable low pulls the line low, high releases it
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      monitor_sense      <= `SENSE_LEVEL;
      monitor_sense_oe_n <= 1'b1;
    end else begin
      monitor_sense <= `SENSE_LEVEL;
      if (ser_s) begin
        monitor_sense_oe_n <= ctrl[`CTRL_SENSE]; // [RQ13]
      end else begin
        monitor_sense_oe_n <= ~rx_s; // [RQ12]
      end
    end
  end

  // apb slave, one wait state so that every output is a flop
  assign acc = psel & penable;
  assign hit = (paddr == `OFS_CTRL) || (paddr == `OFS_STATUS) ||
               (paddr == `OFS_CFG);

  always_comb begin
    read_val = '0;
    case (paddr)
      `OFS_CTRL: begin
        read_val[7:0] = ctrl;
      end
      `OFS_STATUS: begin
        read_val[`ST_RX]      = rx_s;
        read_val[`ST_MODE24]  = mode24;
        read_val[`ST_DIFF]    = diff_active;
        read_val[`ST_SERIAL]  = ser_s;
        read_val[`ST_HOTPLUG] = hpd_s;
        read_val[`ST_HALF]    = cap_state;
        read_val[`ST_ROLE_HI:`ST_ROLE_LO] = role_of(ser_s, dsk_s);
      end
      `OFS_CFG: begin
        read_val[7:0] = cfg_byte; // [RQ14]
      end
      default: begin
        read_val = '0;
      end
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= acc & ~pready;
      pslverr <= acc & ~pready & ~hit;
      prdata  <= (acc && !pready && !pwrite) ? read_val : '0;
    end
  end

  // leaving serial mode drops software settings back to defaults
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl <= `CTRL_RESET;
    end else if (!ser_s) begin
      ctrl <= `CTRL_RESET;
    end else if (acc && pready && pwrite && paddr == `OFS_CTRL) begin
      ctrl <= pwdata[7:0]; // [RQ13]
    end
  end

  a_single_low: // [RQ1]
  assert property (@(posedge clock) disable iff (sys_rst)
    (emit && mode24 && de_w) |=>
      enc_valid && enc_pixel[11:0] == $past(tap_pix[11:0]))
    else $error("low half of 24-bit pixel wrong");
  a_dual_join: // [RQ2] [RQ17]
  assert property (@(posedge clock) disable iff (sys_rst)
    (emit && !mode24 && de_w) |=>
      enc_pixel == {$past(tap_pix[11:0]), $past(first_half)})
    else $error("dual-edge halves not joined");
  a_diff_cross: // [RQ4]
  assert property (@(posedge clock) disable iff (sys_rst)
    (diff_active && $stable(diff_active) && $rose(ref_s)) |->
      $past(pos_s) && !$past(neg_s))
    else $error("differential reference not the crossing");
  a_diff_swing: // [RQ5]
  assert property (@(posedge clock) disable iff (sys_rst)
    diff_active |-> $past(lsw_s))
    else $error("differential clock without low swing");
  a_active_pix: // [RQ6]
  assert property (@(posedge clock) disable iff (sys_rst)
    (emit && de_w) |=> enc_valid && enc_de && enc_pixel == $past(pix_w))
    else $error("active pixel not encoded");
  a_blank_sync: // [RQ7]
  assert property (@(posedge clock) disable iff (sys_rst)
    (emit && !de_w) |=> !enc_de && enc_pixel == 24'h000000 &&
      enc_hsync == $past(hs_w) && enc_vsync == $past(vs_w))
    else $error("blanking syncs not encoded");
  a_pin_pulldown: // [RQ8]
  assert property (@(posedge clock) disable iff (sys_rst)
    (ser_s && open_s == 3'h7) |=> slave_addr_low == 3'h0)
    else $error("open pins did not read zero");
  a_ctrl_role: // [RQ9]
  assert property (@(posedge clock) disable iff (sys_rst)
    (emit && !de_w && pin_role == ROLE_CTRL) |=>
      link_ctrl_in == $past(pins_eff))
    else $error("control inputs not carried in blanking");
  a_trim_role: // [RQ10]
  assert property (@(posedge clock) disable iff (sys_rst)
    (!ser_s && dsk_s) |=> deskew_trim == $past(pins_eff))
    else $error("trim code not taken from pins");
  a_addr_role: // [RQ11]
  assert property (@(posedge clock) disable iff (sys_rst)
    ser_s |=> slave_addr_low == $past(pins_eff))
    else $error("address bits not taken from pins");
  a_sense_auto: // [RQ12]
  assert property (@(posedge clock) disable iff (sys_rst)
    !ser_s |=> monitor_sense_oe_n == !$past(rx_s))
    else $error("monitor sense does not follow receiver");
  a_sense_prog: // [RQ13]
  assert property (@(posedge clock) disable iff (sys_rst)
    ser_s |=> monitor_sense_oe_n == $past(ctrl[`CTRL_SENSE]))
    else $error("monitor sense not software level");
  a_cfg_sample: // [RQ14]
  assert property (@(posedge clock) disable iff (sys_rst)
    (!mode24 && prim) |=> cfg_byte == $past(tap_pix[23:16]))
    else $error("config byte not sampled");
  a_width_strap: // [RQ15]
  assert property (@(posedge clock) disable iff (sys_rst)
    !ser_s |=> mode24 == $past(width_s))
    else $error("bus width does not follow strap");
  a_edge_order: // [RQ16]
  assert property (@(posedge clock) disable iff (sys_rst)
    (!mode24 && cap_state == CAP_FIRST && !prim) |=> cap_state == CAP_FIRST)
    else $error("capture began off the primary edge");
endmodule

// File: tb/pix_source.sv
// Purpose: graphics controller model driving pixel pins and syncs
// Assumes: run is looked at only between pixel periods
// Notes:   its clock stands still at the idle level outside frames
module pix_source (
  input  wire logic        run,
  input  wire logic        mode24,
  input  wire logic        prim_rise,
  input  wire logic        diff,
  input  wire logic [23:0] pixel,
  input  wire logic        de,
  input  wire logic        hs,
  input  wire logic        vs,
  input  wire logic [7:0]  cfg,
  output logic             pix_clk_pos,
  output logic             pix_clk_neg,
  output logic [23:0]      pix_data,
  output logic             data_enable,
  output logic             hsync,
  output logic             vsync
);
  timeunit 1ns;
  timeprecision 100ps;
  // negative input grounded unless differential
  assign pix_clk_neg = diff ? !pix_clk_pos : 1'b0;
  initial begin
    pix_clk_pos = 1'b0;
    pix_data = 24'h000000;
    data_enable = 1'b0;
    hsync = 1'b0;
    vsync = 1'b0;
    forever begin
      wait (run === 1'b1);
      // pins move half a bench clock off its sampling edge
      #2.5 pix_clk_pos = !prim_rise;
      #10;
      data_enable = de;
      hsync = hs;
      vsync = vs;
      // low half first; upper pins carry cfg in 12-bit
      pix_data = mode24 ? pixel : {cfg, 4'h0, pixel[11:0]};
      #30 pix_clk_pos = prim_rise;
      // change 10 ns after the edge, never at it
      #10;
      if (!mode24)
        pix_data[11:0] = pixel[23:12];
      #25 pix_clk_pos = !prim_rise;
      #2.5;
    end
  end
endmodule

// File: tb/dvi_pixel_port_tb_top.sv
// Purpose: self-checking bench of the pixel input port
// Assumes: apb answers with one wait state
// Notes:   straps change only while the pixel clock stands still
`include "dvi_pixel_params.svh"
module dvi_pixel_port_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import dvi_pixel_pkg::*;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  apb_addr_t paddr = 12'h000;
  apb_word_t pwdata = 32'h00000000;
  apb_word_t prdata;
  logic pready, pslverr, pix_clk_pos, pix_clk_neg, data_enable, hsync, vsync;
  logic [23:0] pix_data;
  logic [2:0] multi_pin = 3'h0;
  logic [2:0] multi_pin_open = 3'h0;
  logic serial_if_select = 1'b0;
  logic deskew_enable = 1'b0;
  logic bus_width_strap = 1'b1;
  logic clock_type_strap = 1'b0;
  logic edge_select_strap = 1'b1;
  logic low_swing_mode = 1'b0;
  logic hot_plug_in = 1'b0;
  logic receiver_detect = 1'b0;
  logic enc_valid, enc_de, enc_hsync, enc_vsync;
  logic monitor_sense, monitor_sense_oe_n;
  logic [23:0] enc_pixel;
  logic [2:0] link_ctrl_in, deskew_trim, slave_addr_low;
  logic run = 1'b0;
  logic [23:0] pixel = 24'h000000;
  logic de = 1'b0;
  logic hs = 1'b0;
  logic vs = 1'b0;
  int error_cnt = 0;
  int check_count = 0;
  int npix = 0;

  always #2.5 clock = !clock;
  always @(posedge clock)
    if (enc_valid === 1'b1)
      npix <= npix + 1;

  dvi_pixel_port dut (.clock(clock), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pix_clk_pos(pix_clk_pos), .pix_clk_neg(pix_clk_neg),
    .pix_data(pix_data), .data_enable(data_enable), .hsync(hsync),
    .vsync(vsync), .multi_pin(multi_pin), .multi_pin_open(multi_pin_open),
    .serial_if_select(serial_if_select), .deskew_enable(deskew_enable),
    .bus_width_strap(bus_width_strap), .clock_type_strap(clock_type_strap),
    .edge_select_strap(edge_select_strap), .low_swing_mode(low_swing_mode),
    .hot_plug_in(hot_plug_in), .receiver_detect(receiver_detect),
    .enc_valid(enc_valid), .enc_de(enc_de), .enc_pixel(enc_pixel),
    .enc_hsync(enc_hsync), .enc_vsync(enc_vsync),
    .link_ctrl_in(link_ctrl_in), .deskew_trim(deskew_trim),
    .slave_addr_low(slave_addr_low), .monitor_sense(monitor_sense),
    .monitor_sense_oe_n(monitor_sense_oe_n));

  pix_source src (.run(run), .mode24(bus_width_strap),
    .prim_rise(edge_select_strap), .diff(clock_type_strap), .pixel(pixel),
    .de(de), .hs(hs), .vs(vs), .cfg(8'h9A), .pix_clk_pos(pix_clk_pos),
    .pix_clk_neg(pix_clk_neg), .pix_data(pix_data),
    .data_enable(data_enable), .hsync(hsync), .vsync(vsync));

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // entered right after a rising edge; waits for pready however long
  task automatic rw(input logic wr, input apb_addr_t a, input apb_word_t d,
                    input apb_word_t exp, input logic eerr);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) begin
      n++;
      @(posedge clock);
    end
    // one wait state: pready first seen at the second access edge
    chk("pready_wait", n, 32'h1);
    chk("pslverr", {31'h0, pslverr}, {31'h0, eerr});
    if (!wr)
      chk("prdata", prdata, exp);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic settle();
    repeat (12) @(posedge clock);
  endtask

  // n pixel periods, then outputs hold the last pixel
  task automatic px(input logic [23:0] p, input logic d, h, v, input int n);
    int c0;
    pixel <= p;
    de <= d;
    hs <= h;
    vs <= v;
    c0 = npix;
    run <= 1'b1;
    repeat (n * 16 - 4) @(posedge clock);
    run <= 1'b0;
    repeat (40) @(posedge clock);
    chk("pixels", 32'(npix - c0), 32'(n));
    chk("enc_pixel", {8'h0, enc_pixel}, {8'h0, d ? p : 24'h0});
    chk("enc_de", {31'h0, enc_de}, {31'h0, d});
    chk("enc_hsync", {31'h0, enc_hsync}, {31'h0, h});
    chk("enc_vsync", {31'h0, enc_vsync}, {31'h0, v});
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    #50us;
    error_cnt++;
    conclude();
  end

  initial begin
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    settle();
    chk("oe_n", {31'h0, monitor_sense_oe_n}, 32'h1);
    rw(1'b0, `OFS_CTRL, 0, 32'h13, 1'b0);
    rw(1'b1, `OFS_CTRL, 0, 0, 1'b0);
    rw(1'b1, `OFS_STATUS, 32'hFF, 0, 1'b0);
    rw(1'b0, `OFS_CTRL, 0, 32'h13, 1'b0);
    rw(1'b0, `OFS_STATUS, 0, 32'h02, 1'b0);
    rw(1'b0, 12'h00C, 0, 0, 1'b1);
    $display("test registers done");
    multi_pin <= 3'h5;
    px(24'hA5C3E1, 1'b1, 1'b0, 1'b0, 3);
    chk("ctrl_active", {29'h0, link_ctrl_in}, 32'h0);
    edge_select_strap <= 1'b0;
    settle();
    px(24'h0F0F0F, 1'b0, 1'b0, 1'b1, 2);
    chk("ctrl_blank", {29'h0, link_ctrl_in}, 32'h5);
    $display("test 24-bit done");
    bus_width_strap <= 1'b0;
    edge_select_strap <= 1'b1;
    settle();
    px(24'h123456, 1'b1, 1'b0, 1'b0, 3);
    rw(1'b0, `OFS_CFG, 0, 32'h9A, 1'b0);
    rw(1'b0, `OFS_STATUS, 0, 32'h00, 1'b0);
    edge_select_strap <= 1'b0;
    settle();
    px(24'hFEDCBA, 1'b1, 1'b0, 1'b0, 2);
    $display("test 12-bit done");
    bus_width_strap <= 1'b1;
    edge_select_strap <= 1'b1;
    clock_type_strap <= 1'b1;
    low_swing_mode <= 1'b1;
    settle();
    rw(1'b0, `OFS_STATUS, 0, 32'h06, 1'b0);
    px(24'h5A5A5A, 1'b1, 1'b0, 1'b0, 2);
    low_swing_mode <= 1'b0;
    settle();
    rw(1'b0, `OFS_STATUS, 0, 32'h02, 1'b0);
    clock_type_strap <= 1'b0;
    $display("test clocking done");
    deskew_enable <= 1'b1;
    multi_pin <= 3'h6;
    settle();
    chk("trim", {29'h0, deskew_trim}, 32'h6);
    rw(1'b0, `OFS_STATUS, 0, 32'h42, 1'b0);
    // a large trim takes the first pixel from before its setup window
    px(24'h000000, 1'b0, 1'b1, 1'b0, 2);
    chk("ctrl_trim", {29'h0, link_ctrl_in}, 32'h0);
    // open pads read zero whatever level the pins last had
    multi_pin_open <= 3'h7;
    multi_pin <= 3'h1;
    settle();
    chk("trim_open", {29'h0, deskew_trim}, 32'h0);
    deskew_enable <= 1'b0;
    multi_pin_open <= 3'h0;
    receiver_detect <= 1'b1;
    settle();
    chk("oe_n_rx", {31'h0, monitor_sense_oe_n}, 32'h0);
    chk("sense", {31'h0, monitor_sense}, 32'h0);
    rw(1'b0, `OFS_STATUS, 0, 32'h03, 1'b0);
    receiver_detect <= 1'b0;
    $display("test pins done");
    serial_if_select <= 1'b1;
    hot_plug_in <= 1'b1;
    multi_pin <= 3'h3;
    settle();
    chk("addr", {29'h0, slave_addr_low}, 32'h3);
    multi_pin_open <= 3'h7;
    settle();
    chk("addr_open", {29'h0, slave_addr_low}, 32'h0);
    multi_pin_open <= 3'h0;
    rw(1'b0, `OFS_STATUS, 0, 32'h9A, 1'b0);
    rw(1'b1, `OFS_CTRL, 32'h03, 0, 1'b0);
    settle();
    chk("po_low", {31'h0, monitor_sense_oe_n}, 32'h0);
    rw(1'b0, `OFS_CTRL, 0, 32'h03, 1'b0);
    rw(1'b1, `OFS_CTRL, 32'h17, 0, 1'b0);
    settle();
    chk("po_high", {31'h0, monitor_sense_oe_n}, 32'h1);
    rw(1'b0, `OFS_STATUS, 0, 32'h9A, 1'b0);
    serial_if_select <= 1'b0;
    settle();
    rw(1'b0, `OFS_CTRL, 0, 32'h13, 1'b0);
    $display("test serial done");
    conclude();
  end
endmodule
